// ### hdl/flag_fifo_defs.svh
// Purpose: constants for the dual-pointer queue and its status flags
// Assumes: included by bare name from every design file that needs it
// Notes:   offsets are byte addresses on the register bus
//
// Behaviour
// - output register word excluded from memory count
// - word moved to output register frees its slot
// - separate near-empty and near-full offsets per queue
// - mode selects output-ready or empty meaning; full/input-ready flag same in both modes
// - standard mode ignores reads while empty flag low
// - empty flag on read clock; pointer steps per load
// - fall-through loads word on third edge, flag rises
// - standard empty flag rises on second edge after write
// - write-to-edge skew decides first sync cycle
// - full flag low ignores writes
// - full flag on write clock; pointer steps per write
// - full flag rises by second edge after read
// - read-to-edge skew decides first sync cycle
// - near-empty low at or below offset
// - offsets preset at reset or written by software
// - near-empty rises second edge after crossing write
// - second skew interval decides near-empty sync cycle
// - near-full low from depth minus offset upward
// - status crosses through two flip-flop stages
// - fall-through ignores reads while output-ready low
`ifndef FLAG_FIFO_DEFS_SVH
`define FLAG_FIFO_DEFS_SVH

`define FF_ADDR_W        8
`define FF_CTRL_OFS      8'h00
`define FF_NEAR_EMPTY_OFS 8'h04
`define FF_NEAR_FULL_OFS 8'h08
`define FF_STATUS_OFS    8'h0c
`define FF_FILL_OFS      8'h10
`define FF_MODE_BIT      0
`define FF_ST_EMPTY_BIT  0
`define FF_ST_NEMPTY_BIT 1
`define FF_ST_FULL_BIT   2
`define FF_ST_NFULL_BIT  3
`define FF_OFS_RESET     8'h08
`define FF_MODE_RESET    1'b0
`define FF_RESP_OKAY     2'b00
`define FF_RESP_SLVERR   2'b10

`endif

// ### hdl/flag_fifo_pkg.sv
// Purpose: shared types of the flagged queue
// Assumes: nothing
// Notes:   register selection is decoded once per channel
package flag_fifo_pkg;

  typedef enum logic [2:0]
  {
    SEL_CTRL   = 3'b000,
    SEL_NEMPTY = 3'b001,
    SEL_NFULL  = 3'b010,
    SEL_STATUS = 3'b011,
    SEL_FILL   = 3'b100,
    SEL_NONE   = 3'b111
  } reg_sel_e;

endpackage : flag_fifo_pkg

// ### hdl/gray_sync.sv
// Purpose: two-stage synchroniser for a gray-coded pointer
// Assumes: source changes at most one bit per step
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module gray_sync #(
  parameter int W = 9
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // pointer
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= '0;
      q      <= '0;
    end
    else if (ce)
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end

  sync_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce ##1 ce) |=> q == $past(d, 2))
    else $error("pointer did not cross in two stages");

endmodule : gray_sync

// ### hdl/fifo_store.sv
// Purpose: queue memory whose read data sit in the output register
// Assumes: one write and one load per clock at most
// Notes:   the read register is the queue's output register
`timescale 1ns/1ps
module fifo_store #(
  parameter int WIDTH = 36,
  parameter int AW    = 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // output register load
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge aclk)
  begin
    if (ce && wr_en)
      mem[wr_addr] <= wr_data;
  end

  // previous word is held until the next load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rd_data <= '0;
    else if (ce && rd_en)
      rd_data <= mem[rd_addr];
  end

endmodule : fifo_store

// ### hdl/flag_fifo.sv
// Purpose: one queue with empty/output-ready, full/input-ready, near-empty and near-full flags
// Assumes: writer on port b, reader on port a, both on aclk
// Notes:   pointers still cross through gray synchronisers so flag latency matches the two-clock part
`timescale 1ns/1ps
`include "flag_fifo_defs.svh"
module flag_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 256
) (
  // clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // register bus write
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic      [1:0]       bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  // register bus read
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic      [31:0]      rdata,
  output logic      [1:0]       rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // writing port
  input  wire logic             port_b_wr_en,
  input  wire logic [WIDTH-1:0] port_b_wr_data,
  output logic                  port_b_full_or_inready_flag,
  output logic                  port_b_near_full_flag,
  // reading port
  input  wire logic             port_a_rd_en,
  output logic      [WIDTH-1:0] port_a_rd_data,
  output logic                  port_a_empty_or_outready_flag,
  output logic                  port_a_near_empty_flag
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // configuration
  logic          fall_through_mode;
  logic [AW-1:0] q2_near_empty_offset;
  logic [AW-1:0] q2_near_full_offset;

  ////////////////////////////////////////////////////////////////////////////////
  // pointers
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [PW-1:0] next_wptr;
  logic [PW-1:0] next_rptr;
  logic [PW-1:0] next_wgray;
  logic [PW-1:0] next_rgray;
  logic [PW-1:0] wgray_s;
  logic [PW-1:0] rgray_s;
  logic [PW-1:0] wbin_s;
  logic [PW-1:0] rbin_s;
  logic [PW-1:0] next_rcount;
  logic [PW-1:0] next_wcount;
  logic [PW-1:0] wcount;
  logic          wr_ok;
  logic          load;
  logic          mem_ne;
  logic          out_ready;
  logic          next_out_ready;

  assign wr_ok = ce && port_b_wr_en && port_b_full_or_inready_flag;

  // fall-through loads unrequested when the output register is stale; standard only on a read
  assign load = ce && mem_ne && (fall_through_mode ? (!out_ready || port_a_rd_en)
                                                   : port_a_rd_en);

  assign next_wptr  = wptr + {{AW{1'b0}}, wr_ok};
  assign next_rptr  = rptr + {{AW{1'b0}}, load};
  // sampling the next value keeps the write edge itself out of the sync count
  assign next_wgray = next_wptr ^ (next_wptr >> 1);
  assign next_rgray = next_rptr ^ (next_rptr >> 1);

  always_comb
  begin
    wbin_s[PW-1] = wgray_s[PW-1];
    rbin_s[PW-1] = rgray_s[PW-1];
    for (int i = PW - 2; i >= 0; i--)
    begin
      wbin_s[i] = wbin_s[i+1] ^ wgray_s[i];
      rbin_s[i] = rbin_s[i+1] ^ rgray_s[i];
    end
  end

  // memory count only: a word in the output register has left memory
  assign next_rcount = wbin_s - next_rptr;
  assign next_wcount = next_wptr - rbin_s;

  assign next_out_ready = load ? 1'b1 : ((port_a_rd_en && ce) ? 1'b0 : out_ready);

  gray_sync #(.W(PW)) w_to_r (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (next_wgray),
    .q       (wgray_s)
  );

  gray_sync #(.W(PW)) r_to_w (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (next_rgray),
    .q       (rgray_s)
  );

  fifo_store #(.WIDTH(WIDTH), .AW(AW)) store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .wr_en   (wr_ok),
    .wr_addr (wptr[AW-1:0]),
    .wr_data (port_b_wr_data),
    .rd_en   (load),
    .rd_addr (rptr[AW-1:0]),
    .rd_data (port_a_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read side flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rptr                          <= '0;
      mem_ne                        <= 1'b0;
      out_ready                     <= 1'b0;
      port_a_empty_or_outready_flag <= 1'b0;
      port_a_near_empty_flag        <= 1'b0;
    end
    else if (ce)
    begin
      rptr      <= next_rptr;
      mem_ne    <= next_rcount != '0;
      out_ready <= fall_through_mode && next_out_ready;
      port_a_empty_or_outready_flag <= fall_through_mode ? next_out_ready
                                                         : (next_rcount != '0);
      port_a_near_empty_flag <= next_rcount > {1'b0, q2_near_empty_offset};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write side flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wptr                        <= '0;
      wcount                      <= '0;
      port_b_full_or_inready_flag <= 1'b1;
      port_b_near_full_flag       <= 1'b1;
    end
    else if (ce)
    begin
      wptr   <= next_wptr;
      wcount <= next_wcount;
      port_b_full_or_inready_flag <= next_wcount != DEPTH_P;
      port_b_near_full_flag <= next_wcount < (DEPTH_P - {1'b0, q2_near_full_offset});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register bus
  flag_fifo_pkg::reg_sel_e wr_sel;
  flag_fifo_pkg::reg_sel_e rd_sel;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  logic [31:0] rd_value;

  function automatic flag_fifo_pkg::reg_sel_e decode(input logic [7:0] a);
    flag_fifo_pkg::reg_sel_e s;
    unique case (a)
      `FF_CTRL_OFS:       s = flag_fifo_pkg::SEL_CTRL;
      `FF_NEAR_EMPTY_OFS: s = flag_fifo_pkg::SEL_NEMPTY;
      `FF_NEAR_FULL_OFS:  s = flag_fifo_pkg::SEL_NFULL;
      `FF_STATUS_OFS:     s = flag_fifo_pkg::SEL_STATUS;
      `FF_FILL_OFS:       s = flag_fifo_pkg::SEL_FILL;
      default:            s = flag_fifo_pkg::SEL_NONE;
    endcase
    return s;
  endfunction : decode

  assign wr_sel   = decode(aw_addr_q);
  assign rd_sel   = decode(araddr);
  assign do_write = ce && !awready && !wready && !bvalid;

  always_comb
  begin
    rd_value = 32'h0;
    unique case (rd_sel)
      flag_fifo_pkg::SEL_CTRL:   rd_value[`FF_MODE_BIT] = fall_through_mode;
      flag_fifo_pkg::SEL_NEMPTY: rd_value[AW-1:0] = q2_near_empty_offset;
      flag_fifo_pkg::SEL_NFULL:  rd_value[AW-1:0] = q2_near_full_offset;
      flag_fifo_pkg::SEL_STATUS:
      begin
        rd_value[`FF_ST_EMPTY_BIT]  = port_a_empty_or_outready_flag;
        rd_value[`FF_ST_NEMPTY_BIT] = port_a_near_empty_flag;
        rd_value[`FF_ST_FULL_BIT]   = port_b_full_or_inready_flag;
        rd_value[`FF_ST_NFULL_BIT]  = port_b_near_full_flag;
      end
      flag_fifo_pkg::SEL_FILL:   rd_value[PW-1:0] = wcount;
      flag_fifo_pkg::SEL_NONE:   rd_value = 32'h0;
    endcase
  end

  // address and data are taken independently and held until the response is accepted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `FF_RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp  <= (wr_sel == flag_fifo_pkg::SEL_NONE) ? `FF_RESP_SLVERR : `FF_RESP_OKAY;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // offsets and mode; status and fill are read-only and writes to them are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fall_through_mode    <= `FF_MODE_RESET;
      q2_near_empty_offset <= AW'(`FF_OFS_RESET);
      q2_near_full_offset  <= AW'(`FF_OFS_RESET);
    end
    else if (do_write && w_strb_q[0])
    begin
      unique case (wr_sel)
        flag_fifo_pkg::SEL_CTRL:   fall_through_mode    <= w_data_q[`FF_MODE_BIT];
        flag_fifo_pkg::SEL_NEMPTY: q2_near_empty_offset <= w_data_q[AW-1:0];
        flag_fifo_pkg::SEL_NFULL:  q2_near_full_offset  <= w_data_q[AW-1:0];
        default:                   fall_through_mode    <= fall_through_mode;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= `FF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_value;
        rresp   <= (rd_sel == flag_fifo_pkg::SEL_NONE) ? `FF_RESP_SLVERR : `FF_RESP_OKAY;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  read_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !fall_through_mode && port_a_rd_en && !port_a_empty_or_outready_flag)
      |=> (rptr == $past(rptr)) && $stable(port_a_rd_data))
    else $error("standard read taken while empty flag low");

  write_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && port_b_wr_en && !port_b_full_or_inready_flag) |=> wptr == $past(wptr))
    else $error("write taken while full flag low");

  write_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && port_b_wr_en && port_b_full_or_inready_flag) |=> wptr == $past(wptr) + 1'b1)
    else $error("write pointer did not advance on a write");

  standard_empty_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ok && !fall_through_mode) ##1 (ce && !port_a_rd_en && !fall_through_mode)[*2]
      |=> port_a_empty_or_outready_flag)
    else $error("empty flag not high by second edge after write");

  fall_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_ok && fall_through_mode) ##1 (ce && !port_a_rd_en && fall_through_mode)[*3]
      |=> port_a_empty_or_outready_flag)
    else $error("output ready not high by third edge after write");

  fall_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && fall_through_mode && mem_ne && !out_ready)
      |=> out_ready && rptr == $past(rptr) + 1'b1)
    else $error("fall-through word not loaded with pointer step");

  full_recover_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (load && !port_b_full_or_inready_flag) ##1 (ce && !port_b_wr_en)[*2]
      |=> port_b_full_or_inready_flag)
    else $error("full flag not high by second edge after read");

  gray_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ($countones(next_wgray ^ $past(next_wgray)) <= 1))
    else $error("write pointer gray code changed more than one bit");

  near_empty_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && next_rcount <= {1'b0, q2_near_empty_offset}) |=> !port_a_near_empty_flag)
    else $error("near-empty flag high at or below offset");

endmodule : flag_fifo

// ### sim/port_agent.sv
// Purpose: writer on port b and reader on port a of the flagged queue
// Assumes: both ports run on the single block clock
// Notes:   released write data shows the inverse of the last word, so a stale bus is never trusted
`timescale 1ns/1ps
module port_agent (
  // clock
  input  wire logic        aclk,
  // writing port
  output logic             wr_en,
  output logic      [35:0] wr_data,
  // reading port
  output logic             rd_en,
  input  wire logic [35:0] rd_data
);
  initial
  begin
    wr_en   = 1'b0;
    wr_data = 36'h0;
    rd_en   = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // back-to-back words; only the bench decides to overrun a full queue
  task automatic push(input int n, input logic [35:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge aclk);
      wr_en   <= 1'b1;
      wr_data <= base + 36'(i);
    end
    @(posedge aclk);
    wr_en   <= 1'b0;
    wr_data <= ~(base + 36'(n - 1));
  endtask : push

  // one read request, returns the output register after the request edge
  task automatic pop(output logic [35:0] d);
    @(posedge aclk);
    rd_en <= 1'b1;
    @(posedge aclk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : pop
endmodule : port_agent

// ### sim/flag_fifo_tb.sv
// Purpose: self-checking bench for the flagged queue
// Assumes: register bus master and port agent both drive just after rising edges
// Notes:   whole run stays under a thousand cycles
`timescale 1ns/1ps
`include "flag_fifo_defs.svh"
module flag_fifo_tb;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce      = 1'b1;
  logic [7:0]  awaddr  = 8'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        wr_en;
  logic [35:0] wr_data;
  logic        rd_en;
  logic [35:0] rd_data;
  logic        ef;
  logic        ne;
  logic        ff;
  logic        nf;
  logic [35:0] d;
  logic [31:0] r;
  logic [1:0]  rs;
  int          errors  = 0;
  int          checked = 0;

  always #25 aclk = ~aclk;

  flag_fifo #(.WIDTH(36), .DEPTH(256)) DUT (
    .aclk, .aresetn, .ce,
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .port_b_wr_en(wr_en), .port_b_wr_data(wr_data),
    .port_b_full_or_inready_flag(ff), .port_b_near_full_flag(nf),
    .port_a_rd_en(rd_en), .port_a_rd_data(rd_data),
    .port_a_empty_or_outready_flag(ef), .port_a_near_empty_flag(ne)
  );

  port_agent ag (.aclk, .wr_en, .wr_data, .rd_en, .rd_data);

  //////////////////////////////////////////////////////////////////////////////
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (bvalid !== 1'b1 || awvalid || wvalid)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    s = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (rvalid !== 1'b1)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    v = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  task automatic results;
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    results();
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    tick(1);
    chk("empty", 36'h0, 36'(ef));
    chk("near_empty", 36'h0, 36'(ne));
    chk("full", 36'h1, 36'(ff));
    chk("near_full", 36'h1, 36'(nf));
    axr(`FF_CTRL_OFS, r, rs);
    chk("mode", 36'h0, 36'(r));
    axr(`FF_NEAR_EMPTY_OFS, r, rs);
    chk("ne_ofs", 36'h8, 36'(r));
    axr(`FF_NEAR_FULL_OFS, r, rs);
    chk("nf_ofs", 36'h8, 36'(r));
    axr(`FF_STATUS_OFS, r, rs);
    chk("status", 36'hc, 36'(r));
    axr(8'h40, r, rs);
    chk("bad_rresp", 36'(`FF_RESP_SLVERR), 36'(rs));
    axw(8'h40, 32'h5, rs);
    chk("bad_bresp", 36'(`FF_RESP_SLVERR), 36'(rs));
    axw(`FF_NEAR_EMPTY_OFS, 32'h2, rs);
    chk("ok_bresp", 36'(`FF_RESP_OKAY), 36'(rs));
    axr(`FF_NEAR_EMPTY_OFS, r, rs);
    chk("ne_ofs_new", 36'h2, 36'(r));
    chk("ok_rresp", 36'(`FF_RESP_OKAY), 36'(rs));
    axr(`FF_NEAR_FULL_OFS, r, rs);
    chk("nf_ofs_kept", 36'h8, 36'(r));
    // standard mode: read two edges after the write is still refused
    ag.push(1, 36'h9_0000_0001);
    ag.pop(d);
    chk("early_read", 36'h0, d);
    chk("empty_edge2", 36'h1, 36'(ef));
    ag.pop(d);
    chk("std_word", 36'h9_0000_0001, d);
    tick(2);
    chk("empty_drained", 36'h0, 36'(ef));
    // near-empty crossing at offset plus one
    ag.push(3, 36'h3_0000_0000);
    tick(1);
    chk("ne_edge1", 36'h0, 36'(ne));
    tick(1);
    chk("ne_edge2", 36'h1, 36'(ne));
    ag.pop(d);
    chk("order0", 36'h3_0000_0000, d);
    tick(3);
    chk("ne_after_read", 36'h0, 36'(ne));
    for (int i = 1; i < 3; i++)
    begin
      ag.pop(d);
      chk("order", 36'h3_0000_0000 + 36'(i), d);
    end
    // fill to the brim, overrun once, then drain
    ag.push(247, 36'h0);
    tick(3);
    chk("nf_below", 36'h1, 36'(nf));
    ag.push(1, 36'd247);
    tick(3);
    chk("nf_at", 36'h0, 36'(nf));
    ag.push(8, 36'd248);
    #1;
    chk("full_now", 36'h0, 36'(ff));
    axr(`FF_FILL_OFS, r, rs);
    chk("fill", 36'h100, 36'(r));
    ag.push(1, 36'hbad);
    ag.pop(d);
    chk("drain0", 36'h0, d);
    tick(1);
    chk("full_edge1", 36'h0, 36'(ff));
    tick(1);
    chk("full_edge2", 36'h1, 36'(ff));
    for (int i = 1; i < 256; i++)
    begin
      ag.pop(d);
      chk("drain", 36'(i), d);
    end
    // fall-through mode, switched while the queue is empty
    tick(2);
    axw(`FF_CTRL_OFS, 32'h1, rs);
    ag.push(1, 36'haa);
    tick(2);
    chk("or_edge2", 36'h0, 36'(ef));
    tick(1);
    chk("or_edge3", 36'h1, 36'(ef));
    chk("ft_word", 36'haa, rd_data);
    ag.push(2, 36'hb0);
    tick(4);
    chk("ne_ft_two", 36'h0, 36'(ne));
    ag.push(1, 36'hb2);
    tick(2);
    chk("ne_ft_three", 36'h1, 36'(ne));
    for (int i = 0; i < 3; i++)
    begin
      ag.pop(d);
      chk("ft_next", 36'hb0 + 36'(i), d);
    end
    ag.pop(d);
    chk("ft_last", 36'hb2, d);
    chk("or_low", 36'h0, 36'(ef));
    ag.pop(d);
    chk("ft_ignored", 36'hb2, d);
    // a frozen clock enable parks a word between the synchroniser stages
    ag.push(1, 36'hc0);
    ce <= 1'b0;
    tick(6);
    chk("frozen_flag", 36'h0, 36'(ef));
    @(posedge aclk);
    ce <= 1'b1;
    tick(2);
    chk("thawed_edge2", 36'h0, 36'(ef));
    tick(1);
    chk("thawed_edge3", 36'h1, 36'(ef));
    chk("thawed_word", 36'hc0, rd_data);
    results();
  end
endmodule : flag_fifo_tb
